// ==== rtl/trig_sel_pkg.sv ====
// constants and types for the sequencer trigger select block
package trig_sel_pkg;
    localparam int          NUM_SEQ         = 4;
    localparam int          CODE_W          = 4;
    localparam logic [11:0] TRIG_SEL_OFFSET = 12'h014;
    localparam logic [11:0] CTRL_OFFSET     = 12'h100;
    localparam logic [11:0] STATUS_OFFSET   = 12'h104;
    localparam int          SEQ0_LSB        = 0;
    localparam int          SEQ1_LSB        = 4;
    localparam int          SEQ2_LSB        = 8;
    localparam int          SEQ3_LSB        = 12;
    localparam int          FIELDS_W        = 16;
    localparam logic [15:0] TRIG_SEL_RESET  = 16'h0000;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef enum logic [3:0] {
        SRC_CONTROLLER = 4'h0,
        SRC_EXTERNAL   = 4'h4,
        SRC_TIMER      = 4'h5,
        SRC_PWM0       = 4'h6,
        SRC_PWM1       = 4'h7,
        SRC_PWM2       = 4'h8,
        SRC_ALWAYS     = 4'hF
    } trig_src_t;

    // raw event sources shared by all sequencers
    typedef struct packed {
        logic       external_trigger_pin;
        logic       timer_trigger;
        logic [2:0] pwm_trigger;
    } trig_inputs_t;
endpackage : trig_sel_pkg

// ==== rtl/adc_sequencer_trigger_select.sv ====
// axi4-lite trigger source selector for four sample sequencers
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module adc_sequencer_trigger_select
    import trig_sel_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire trig_inputs_t         trig_in,
    output logic [NUM_SEQ-1:0]        seq_start
);
    if (ADDR_W < 12) begin : g_addr_check
        $error("ADDR_W must be at least 12");
    end

    logic [FIELDS_W-1:0]  sel_reg,   sel_next;
    logic [NUM_SEQ-1:0]   ctrl_req_reg, ctrl_req_next;
    logic [NUM_SEQ-1:0]   start_reg, start_next;
    logic [NUM_SEQ-1:0]   hist_reg,  hist_next;
    logic                 pin_s1_reg, pin_s2_reg, pin_s3_reg;
    logic                 aw_hold_reg, aw_hold_next;
    logic                 w_hold_reg,  w_hold_next;
    logic [ADDR_W-1:0]    awaddr_reg,  awaddr_next;
    logic [31:0]          wdata_reg,   wdata_next;
    logic [3:0]           wstrb_reg,   wstrb_next;
    logic                 bvalid_reg,  bvalid_next;
    logic [1:0]           bresp_reg,   bresp_next;
    logic                 rvalid_reg,  rvalid_next;
    logic [1:0]           rresp_reg,   rresp_next;
    logic [31:0]          rdata_reg,   rdata_next;
    logic                 pin_pulse;
    logic [NUM_SEQ-1:0]   event_hit;

    // write channel: address and data taken in either order
    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;
    assign seq_start     = start_reg;

    // rising edge of synchronised pin; stage one feeds only stage two
    assign pin_pulse = pin_s2_reg && !pin_s3_reg;

    always_comb begin
        logic             aw_have, w_have;
        logic [ADDR_W-1:0] wa;
        logic [31:0]      wd;
        logic [3:0]       ws;
        aw_have      = aw_hold_reg || s_axi_awvalid;
        w_have       = w_hold_reg || s_axi_wvalid;
        wa           = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
        wd           = w_hold_reg ? wdata_reg : s_axi_wdata;
        ws           = w_hold_reg ? wstrb_reg : s_axi_wstrb;
        aw_hold_next = aw_hold_reg;
        w_hold_next  = w_hold_reg;
        awaddr_next  = awaddr_reg;
        wdata_next   = wdata_reg;
        wstrb_next   = wstrb_reg;
        bvalid_next  = bvalid_reg && !s_axi_bready;
        bresp_next   = bresp_reg;
        sel_next     = sel_reg;
        ctrl_req_next = 4'h0;
        if (!bvalid_reg && aw_have && w_have) begin
            aw_hold_next = 1'b0;
            w_hold_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = RESP_OKAY;
            if (wa[11:2] == TRIG_SEL_OFFSET[11:2]) begin
                if (ws[0]) sel_next[7:0]  = wd[7:0];
                if (ws[1]) sel_next[15:8] = wd[15:8];
            end else if (wa[11:2] == CTRL_OFFSET[11:2]) begin
                if (ws[0]) ctrl_req_next = wd[NUM_SEQ-1:0];
            end else if (wa[11:2] != STATUS_OFFSET[11:2]) begin
                bresp_next = RESP_SLVERR;
            end
        end else if (!bvalid_reg) begin
            if (s_axi_awvalid && !aw_hold_reg) begin
                aw_hold_next = 1'b1;
                awaddr_next  = s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_hold_reg) begin
                w_hold_next = 1'b1;
                wdata_next  = s_axi_wdata;
                wstrb_next  = s_axi_wstrb;
            end
        end
    end

    always_comb begin
        rvalid_next = rvalid_reg && !s_axi_rready;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (!rvalid_reg && s_axi_arvalid) begin
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            if (s_axi_araddr[11:2] == TRIG_SEL_OFFSET[11:2])
                rdata_next = {16'h0000, sel_reg};
            else if (s_axi_araddr[11:2] == CTRL_OFFSET[11:2])
                rdata_next = 32'h0000_0000;
            else if (s_axi_araddr[11:2] == STATUS_OFFSET[11:2])
                rdata_next = {28'h000_0000, hist_reg};
            else begin
                rdata_next = 32'h0000_0000;
                rresp_next = RESP_SLVERR;
            end
        end
    end

    // per-sequencer source decode
    always_comb begin
        for (int i = 0; i < NUM_SEQ; i++) begin
            unique case (sel_reg[i*CODE_W +: CODE_W])
                SRC_CONTROLLER: event_hit[i] = ctrl_req_reg[i];
                SRC_EXTERNAL:   event_hit[i] = pin_pulse;
                SRC_TIMER:      event_hit[i] = trig_in.timer_trigger;
                SRC_PWM0:       event_hit[i] = trig_in.pwm_trigger[0];
                SRC_PWM1:       event_hit[i] = trig_in.pwm_trigger[1];
                SRC_PWM2:       event_hit[i] = trig_in.pwm_trigger[2];
                SRC_ALWAYS:     event_hit[i] = 1'b1;
                default:        event_hit[i] = 1'b0;
            endcase
        end
        start_next = event_hit;
        hist_next  = hist_reg | event_hit;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_reg      <= TRIG_SEL_RESET;
            ctrl_req_reg <= 4'h0;
            start_reg    <= 4'h0;
            hist_reg     <= 4'h0;
            pin_s1_reg   <= 1'b0;
            pin_s2_reg   <= 1'b0;
            pin_s3_reg   <= 1'b0;
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            awaddr_reg   <= '0;
            wdata_reg    <= 32'h0000_0000;
            wstrb_reg    <= 4'h0;
            bvalid_reg   <= 1'b0;
            bresp_reg    <= RESP_OKAY;
            rvalid_reg   <= 1'b0;
            rresp_reg    <= RESP_OKAY;
            rdata_reg    <= 32'h0000_0000;
        end else begin
            sel_reg      <= sel_next;
            ctrl_req_reg <= ctrl_req_next;
            start_reg    <= start_next;
            hist_reg     <= hist_next;
            pin_s1_reg   <= trig_in.external_trigger_pin;
            pin_s2_reg   <= pin_s1_reg;
            pin_s3_reg   <= pin_s2_reg;
            aw_hold_reg  <= aw_hold_next;
            w_hold_reg   <= w_hold_next;
            awaddr_reg   <= awaddr_next;
            wdata_reg    <= wdata_next;
            wstrb_reg    <= wstrb_next;
            bvalid_reg   <= bvalid_next;
            bresp_reg    <= bresp_next;
            rvalid_reg   <= rvalid_next;
            rresp_reg    <= rresp_next;
            rdata_reg    <= rdata_next;
        end
    end

    chk_seq0_reset: assert property (@(posedge aclk) !aresetn |=> sel_reg[3:0] == 4'h0)
        else $error("sequencer 0 code not zero after reset");
    chk_seq1_reset: assert property (@(posedge aclk) !aresetn |=> sel_reg[7:4] == 4'h0)
        else $error("sequencer 1 code not zero after reset");
    chk_seq2_reset: assert property (@(posedge aclk) !aresetn |=> sel_reg[11:8] == 4'h0)
        else $error("sequencer 2 code not zero after reset");
    chk_rsvd_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == TRIG_SEL_OFFSET[11:2])
        |=> s_axi_rdata == {16'h0000, $past(sel_reg)})
        else $error("select register read wrong");
    chk_reserved_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        (sel_reg[3:0] inside {[4'h1:4'h3], [4'h9:4'hE]}) |=> !seq_start[0])
        else $error("reserved code started a sequence");
    chk_timer_route: assert property (@(posedge aclk) disable iff (!aresetn)
        (sel_reg[3:0] == 4'h5) |=> seq_start[0] == $past(trig_in.timer_trigger))
        else $error("timer trigger not routed");
    chk_pwm1_route: assert property (@(posedge aclk) disable iff (!aresetn)
        (sel_reg[7:4] == 4'h7) |=> seq_start[1] == $past(trig_in.pwm_trigger[1]))
        else $error("pwm1 trigger not routed");
    chk_always_on: assert property (@(posedge aclk) disable iff (!aresetn)
        (sel_reg[15:12] == 4'hF)[*2] |=> seq_start[3])
        else $error("continuous mode did not trigger");
    sequence pin_rise_s;
        !pin_s3_reg && pin_s2_reg;
    endsequence
    chk_pin_single: assert property (@(posedge aclk) disable iff (!aresetn)
        (pin_rise_s and sel_reg[11:8] == 4'h4) |=> seq_start[2] ##1 !seq_start[2])
        else $error("pin event not a single pulse");
    chk_ctrl_start: assert property (@(posedge aclk) disable iff (!aresetn)
        (sel_reg[3:0] == 4'h0 && ctrl_req_reg[0]) |=> seq_start[0])
        else $error("controller request not started");

    // remaining sequencers, bus handshake and status bookkeeping
    sequence sel_wr_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && s_axi_awaddr[11:2] == TRIG_SEL_OFFSET[11:2];
    endsequence
    chk_seq3_reset: assert property (@(posedge aclk) !aresetn |=> sel_reg[15:12] == 4'h0)
        else $error("sequencer 3 code not zero after reset");
    chk_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == TRIG_SEL_OFFSET[11:2])
        |=> s_axi_rdata[31:16] == 16'h0000) else $error("reserved select bits not zero");
    chk_pwm0_route: assert property (@(posedge aclk) disable iff (!aresetn)
        (sel_reg[3:0] == 4'h6) |=> seq_start[0] == $past(trig_in.pwm_trigger[0]))
        else $error("pwm0 trigger not routed");
    chk_pwm2_route: assert property (@(posedge aclk) disable iff (!aresetn)
        (sel_reg[11:8] == 4'h8) |=> seq_start[2] == $past(trig_in.pwm_trigger[2]))
        else $error("pwm2 trigger not routed");
    chk_timer_seq3: assert property (@(posedge aclk) disable iff (!aresetn)
        (sel_reg[15:12] == 4'h5) |=> seq_start[3] == $past(trig_in.timer_trigger))
        else $error("timer trigger not routed to sequencer 3");
    chk_rsvd_seq1: assert property (@(posedge aclk) disable iff (!aresetn)
        (sel_reg[7:4] inside {[4'h1:4'h3], [4'h9:4'hE]}) |=> !seq_start[1])
        else $error("reserved code started sequencer 1");
    chk_rsvd_seq2: assert property (@(posedge aclk) disable iff (!aresetn)
        (sel_reg[11:8] inside {[4'h1:4'h3], [4'h9:4'hE]}) |=> !seq_start[2])
        else $error("reserved code started sequencer 2");
    chk_rsvd_seq3: assert property (@(posedge aclk) disable iff (!aresetn)
        (sel_reg[15:12] inside {[4'h1:4'h3], [4'h9:4'hE]}) |=> !seq_start[3])
        else $error("reserved code started sequencer 3");
    chk_ctrl_seq1: assert property (@(posedge aclk) disable iff (!aresetn)
        (sel_reg[7:4] == 4'h0 && ctrl_req_reg[1]) |=> seq_start[1])
        else $error("controller request not started on sequencer 1");
    chk_ctrl_seq2: assert property (@(posedge aclk) disable iff (!aresetn)
        (sel_reg[11:8] == 4'h0 && ctrl_req_reg[2]) |=> seq_start[2])
        else $error("controller request not started on sequencer 2");
    chk_ctrl_seq3: assert property (@(posedge aclk) disable iff (!aresetn)
        (sel_reg[15:12] == 4'h0 && ctrl_req_reg[3]) |=> seq_start[3])
        else $error("controller request not started on sequencer 3");
    chk_ctrl_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        (|ctrl_req_reg) |=> ctrl_req_reg == 4'h0)
        else $error("controller request did not clear itself");
    chk_pin_seq0: assert property (@(posedge aclk) disable iff (!aresetn)
        (pin_rise_s ##0 sel_reg[3:0] == 4'h4) |=> seq_start[0])
        else $error("pin event not routed to sequencer 0");
    chk_always_seq0: assert property (@(posedge aclk) disable iff (!aresetn)
        (sel_reg[3:0] == 4'hF) |=> seq_start[0])
        else $error("continuous mode did not trigger sequencer 0");
    chk_low_write: assert property (@(posedge aclk) disable iff (!aresetn)
        (sel_wr_s ##0 s_axi_wstrb[0]) |=> sel_reg[7:0] == $past(s_axi_wdata[7:0]))
        else $error("low select byte not written");
    chk_high_write: assert property (@(posedge aclk) disable iff (!aresetn)
        (sel_wr_s ##0 s_axi_wstrb[1]) |=> sel_reg[15:8] == $past(s_axi_wdata[15:8]))
        else $error("high select byte not written");
    chk_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response dropped early");
    chk_write_refused: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    chk_read_refused: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while response pending");
    chk_status_covers: assert property (@(posedge aclk) disable iff (!aresetn)
        (hist_reg & seq_start) == seq_start)
        else $error("status misses a started sequencer");
    chk_status_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        (|hist_reg) |=> (hist_reg & $past(hist_reg)) == $past(hist_reg))
        else $error("status bit lost");
endmodule : adc_sequencer_trigger_select

// ==== testbench/tb_top.sv ====
// self-checking bench for the sequencer trigger select block
`timescale 1ns/1ps
module tb_top;
    import trig_sel_pkg::*;
    logic         aclk;
    logic         aresetn;
    logic [11:0]  awaddr, araddr;
    logic         awvalid, wvalid, bready, arvalid, rready;
    logic         awready, wready, bvalid, arready, rvalid;
    logic [31:0]  wdata, rdata, rd;
    logic [3:0]   wstrb, seq_start;
    logic [1:0]   bresp, rresp, resp;
    trig_inputs_t trig_in;
    logic [15:0]  sel_model;
    logic [4:0]   src;
    int           error_cnt, n_compared;
    logic [31:0]  corner [3] = '{32'h0000_F840, 32'h0000_5673, 32'hFFFF_9E21};

    adc_sequencer_trigger_select #(.ADDR_W(12)) i_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .trig_in(trig_in), .seq_start(seq_start)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict

    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        bit aw_ok, w_ok, b_ok;
        aw_ok = 0; w_ok = 0; b_ok = 0;
        @(posedge aclk);
        awaddr <= a; wdata <= d; wstrb <= s;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (!b_ok) begin
            @(posedge aclk);
            if (b_ok == 0 && aw_ok && w_ok && bvalid) begin
                resp = bresp; b_ok = 1; bready <= 1'b0;
            end
            if (!aw_ok && awready) begin
                aw_ok = 1; awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1; wvalid <= 1'b0;
            end
        end
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a);
        bit ar_ok, r_ok;
        ar_ok = 0; r_ok = 0;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!r_ok) begin
            @(posedge aclk);
            if (ar_ok && rvalid) begin
                rd = rdata; resp = rresp; r_ok = 1; rready <= 1'b0;
            end
            if (!ar_ok && arready) begin
                ar_ok = 1; arvalid <= 1'b0;
            end
        end
    endtask : axi_read

    function automatic int exp_cnt(input logic [3:0] c, input bit ctrl, input logic [4:0] ev);
        if (c == 4'hF) return 10;
        if (ctrl) return int'(c == 4'h0);
        case (c)
            4'h4: return int'(ev[4]);
            4'h5: return int'(ev[3]);
            4'h6: return int'(ev[0]);
            4'h7: return int'(ev[1]);
            4'h8: return int'(ev[2]);
            default: return 0;
        endcase
    endfunction : exp_cnt

    // counts start cycles per sequencer over ten cycles, firing the chosen sources first when ctrl is 0
    task automatic run_window(input bit ctrl);
        int n [4];
        n = '{0, 0, 0, 0};
        for (int k = 0; k < 10; k++) begin
            @(posedge aclk);
            if (!ctrl && k == 0) trig_in <= src;
            if (!ctrl && k == 1) trig_in <= {src[4], 4'h0};
            #1;
            for (int i = 0; i < 4; i++) n[i] += int'(seq_start[i] === 1'b1);
        end
        for (int i = 0; i < 4; i++) begin
            check(n[i], exp_cnt(sel_model[4*i +: 4], ctrl, src));
        end
    endtask : run_window

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        give_verdict();
    end

    initial begin
        logic [31:0] d;
        logic [3:0]  s;
        aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
        arvalid = 1'b0; rready = 1'b0; awaddr = '0; araddr = '0;
        wdata = '0; wstrb = '0; trig_in = '0; src = '0;
        error_cnt = 0; n_compared = 0;
        sel_model = TRIG_SEL_RESET;
        void'($urandom(1680));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(TRIG_SEL_OFFSET);
        check(rd, 32'h0000_0000);
        axi_read(12'h0F0);
        check(rd, 32'h0000_0000);
        check(resp, RESP_SLVERR);
        axi_write(12'h0F0, 32'hFFFF_FFFF, 4'hF);
        check(resp, RESP_SLVERR);
        for (int it = 0; it < 24; it++) begin
            d = (it < 3) ? corner[it] : $urandom;
            s = (it < 3) ? 4'hF : 4'($urandom);
            src = (it < 3) ? 5'h1F : 5'($urandom);
            axi_write(TRIG_SEL_OFFSET, d, s);
            check(resp, RESP_OKAY);
            if (s[0]) sel_model[7:0] = d[7:0];
            if (s[1]) sel_model[15:8] = d[15:8];
            axi_read(TRIG_SEL_OFFSET);
            check(rd, {16'h0000, sel_model});
            run_window(1'b0);
            @(posedge aclk);
            trig_in <= '0;
            repeat (4) @(posedge aclk);
            fork
                axi_write(CTRL_OFFSET, 32'h0000_000F, 4'hF);
                run_window(1'b1);
            join
        end
        axi_read(STATUS_OFFSET);
        check(rd, 32'h0000_000F);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        sel_model = TRIG_SEL_RESET;
        axi_read(TRIG_SEL_OFFSET);
        check(rd, {16'h0000, sel_model});
        axi_read(STATUS_OFFSET);
        check(rd, 32'h0000_0000);
        give_verdict();
    end
endmodule : tb_top
